// ==== include/dcr_pkg.sv ====
/*
 Package for the disk channel configuration and test register bank:
 register addresses, bit positions, reset values and carrier structs.
 Assumes an eight-bit multiplexed address/data microprocessor bus.
*/
package dcr_pkg;

    // ------------------------------------------------------------
    // Register addresses on the multiplexed bus
    // ------------------------------------------------------------
    localparam logic [7:0] A_WIN_REF = 8'hC4;
    localparam logic [7:0] A_WIN_VCO = 8'hC5;
    localparam logic [7:0] A_FAST_DAC = 8'hC8;
    localparam logic [7:0] A_BOOST_DAC = 8'hC9;
    localparam logic [7:0] A_HYST_DAC = 8'hCA;
    localparam logic [7:0] A_SRV_FAST = 8'hCB;
    localparam logic [7:0] A_SRV_BOOST = 8'hCC;
    localparam logic [7:0] A_SRV_HYST = 8'hCD;
    localparam logic [7:0] A_SYNTH_REF = 8'hCE;
    localparam logic [7:0] A_SYNTH_VCO = 8'hCF;
    localparam logic [7:0] A_PRECOMP_BASE = 8'hD0;
    localparam logic [7:0] A_CHAN_CTL = 8'hDD;
    localparam logic [7:0] A_DECODE_POL = 8'hDE;
    localparam logic [7:0] A_PORT_VER = 8'hDF;
    localparam logic [7:0] A_TEST_SEL = 8'hE0;
    localparam logic [7:0] A_TEST_READ_ONE = 8'hE1;
    localparam logic [3:0] PRECOMP_LAST = 4'hA;

    // ------------------------------------------------------------
    // Bit positions
    // ------------------------------------------------------------
    localparam int CC_BUSY_OVERRIDE = 2;
    localparam int CC_SOFT_PD = 3;
    localparam int CC_FULL_PD = 4;
    localparam int CC_TEST_UNLOCK = 7;
    localparam int DP_DEC_ERR = 0;
    localparam int DP_FILL = 1;
    localparam int DP_WMON = 2;
    localparam int DP_RAW_POL = 3;
    localparam int DP_WR_POL = 4;
    localparam int DP_VLOCK_LO = 5;
    localparam int DP_VLOCK_HI = 6;
    localparam int DP_PRESCALE = 7;
    localparam int T_PHASE_DET_IO_TEST = 0;
    localparam int T_UP = 1;
    localparam int T_DN = 2;
    localparam int T_OPEN = 3;
    localparam int T_CNT = 4;
    localparam int T_ILB = 5;
    localparam int T_DC = 6;
    localparam int T_PATTERN_RECOGNIZER_TEST = 7;
    localparam int DAC_EN = 5;

    // ------------------------------------------------------------
    // Reset and initial values
    // ------------------------------------------------------------
    localparam logic [7:0] CHAN_CTL_RST = 8'h10;
    localparam logic [7:0] PD_KEEP_MASK = 8'h18;
    localparam logic [7:0] DECODE_POL_RST = 8'h00;
    localparam logic [7:0] TEST_RST = 8'h00;
    localparam logic [7:0] DIV8_ONES = 8'hFF;
    localparam logic [3:0] DIV4_ONES = 4'hF;
    localparam logic [4:0] DIV5_ONES = 5'h1F;

    // Pins from outside the clock domain
    typedef struct packed {
        logic ale;
        logic cs_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] ad;
        logic hard_reset_in;
        logic read_pulse_in;
        logic servo_gate;
        logic read_gate;
        logic encoder_enable;
    } dcr_pins_t;

    localparam dcr_pins_t PINS_IDLE = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};

    // Status and data from channel logic on core_clk
    typedef struct packed {
        logic dec_err_evt;
        logic wpc_data_int;
        logic disk_writing;
        logic delayed_read_out_int;
        logic window_clock_out_int;
        logic [7:0] fs_ref_cnt;
        logic [7:0] fs_vco_cnt;
        logic [3:0] ws_ref_cnt;
        logic [4:0] ws_vco_cnt;
        logic [7:0] pd_status;
        logic [4:0] pattern_recognizer_test_sel;
        logic pattern_recognizer_test_data;
    } dcr_core_in_t;

    // Controls to the channel logic
    typedef struct packed {
        logic illegal_code_fill_select;
        logic window_monitor_enable;
        logic [1:0] velocity_lock_sel;
        logic reference_prescale_enable;
        logic [7:0] synth_ref_div;
        logic [7:0] synth_vco_div;
        logic [3:0] window_ref_div;
        logic [4:0] window_vco_div;
        logic [21:0][3:0] precomp_nibbles;
        logic precomp_const_valid;
        logic [4:0] precomp_const;
        logic [5:0] fast_dac;
        logic [5:0] boost_dac;
        logic [6:0] hyst_dac;
        logic soft_powerdown;
        logic full_soft_powerdown;
        logic phase_det_io_test;
        logic synth_block_ref;
        logic synth_block_vco;
        logic synth_open_loop_test;
        logic divider_count_test;
        logic internal_loop_test;
        logic write_dc_erase_test;
        logic pattern_recognizer_test;
    } dcr_ctl_t;

endpackage

// ==== logic/dcr_regs.sv ====
/*
 Register bank of the disk channel data separator: configuration,
 open-drain ports, version, synthesizer dividers, precompensation
 nibbles, converter codes and the first test register.
 Assumes bus pins are asynchronous and are synchronised here, and that
 core_i comes from channel logic clocked by core_clk.
*/
// Notes on behaviour
// - Decoder error sets flag; soft reset/write clears
// - Fill bit picks NRZ ones or zeros
// - Window monitor bit enables monitor outputs
// - Polarity bits pick raw input, write output edges
// - Two bits select velocity lock time
// - Prescale bit halves crystal before reference divider
// - Top port bits read fixed version number
// - Port one pulls low; only hard reset clears
// - Synthesizer dividers are eight-bit unsigned values
// - Window dividers are four and five bits
// - Two nibbles per register; last pair swapped
// - Converter codes survive soft powerdown only
// - Servo gate picks servo or data codes
// - Code bits 4-0, enable bit5, hysteresis bit6
// - Tests act only with test unlock set
// - Pump tests block reference or VCO input
// - Both pump tests set means neither acts
// - Test address reads phase detector signals
// - Counter test reads live divider counts
// - Erase test holds write output inactive
// - Recognizer test reads live selection and data
// - Busy override keeps pads coupled during disk access
`timescale 1ns/100ps
module dcr_regs
    import dcr_pkg::*;
#(
    parameter logic [2:0] VERSION_ID = 3'h1 // Arbitrary value
)(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire dcr_pins_t pins_i,
    input wire dcr_core_in_t core_i,
    output logic [7:0] ad_o,
    output logic ad_oe,
    output logic [4:0] port_o,
    output logic [4:0] port_oe,
    output logic read_pulse_norm,
    output logic precomp_write_out,
    output logic delayed_read_out,
    output logic window_clock_out,
    output dcr_ctl_t ctl_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        dcr_pins_t s1;
        dcr_pins_t s2;
        logic wr_act;
        logic [7:0] addr;
        logic [7:0] wdat;
        logic [7:0] chan;
        logic [7:0] dpc;
        logic [7:0] tsel;
        logic [4:0] port;
        logic [7:0] sref;
        logic [7:0] svco;
        logic [3:0] wref;
        logic [4:0] wvco;
        logic [21:0][3:0] nib;
        logic [4:0] pconst;
        logic pconst_v;
        logic [5:0] fdac;
        logic [5:0] bdac;
        logic [6:0] hdac;
        logic [5:0] sfdac;
        logic [5:0] sbdac;
        logic [6:0] shdac;
        logic [7:0] ad;
        logic ad_oe;
        logic rp;
        logic wpc;
        logic dly;
        logic wck;
        dcr_ctl_t ctl;
    } dcr_state_t;

    localparam dcr_state_t ST_RST = '{
        s1: PINS_IDLE,
        s2: PINS_IDLE,
        chan: CHAN_CTL_RST,
        sref: DIV8_ONES,
        svco: DIV8_ONES,
        wref: DIV4_ONES,
        wvco: DIV5_ONES,
        default: '0
    };

    dcr_state_t q;
    dcr_state_t d;

    logic hr;
    logic pd_any;
    logic busy;
    logic bus_ok;
    logic wr_now;
    logic commit;
    logic wpc_hit;
    logic [3:0] wpc_idx;
    logic [7:0] test_eff;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Precompensation register decode: hit flag and pair index
    function automatic logic [4:0] precomp_decode(input logic [7:0] a);
        logic [7:0] off;
        off = a - A_PRECOMP_BASE;
        if (a >= A_PRECOMP_BASE && off[3:0] <= PRECOMP_LAST && off[7:4] == 4'h0) begin
            return {1'b1, off[3:0]};
        end
        return 5'h00;
    endfunction

    // Servo gate selects which bank feeds a converter
    function automatic logic [6:0] dac_pick(input logic [6:0] data_code, input logic [6:0] servo_code,
                                            input logic servo);
        return servo ? servo_code : data_code;
    endfunction

    // Read data for the latched address
    function automatic logic [7:0] read_word(input dcr_state_t s, input dcr_core_in_t c,
                                             input logic hit, input logic [3:0] idx);
        logic [7:0] r;
        r = 8'h00;
        case (s.addr)
            A_CHAN_CTL: r = s.chan;
            A_DECODE_POL: r = s.dpc;
            A_PORT_VER: r = {VERSION_ID, s.port};
            A_SYNTH_REF: r = s.ctl.divider_count_test ? c.fs_ref_cnt : s.sref;
            A_SYNTH_VCO: r = s.ctl.divider_count_test ? c.fs_vco_cnt : s.svco;
            A_WIN_REF: r = {4'h0, s.ctl.divider_count_test ? c.ws_ref_cnt : s.wref};
            A_WIN_VCO: r = {3'h0, s.ctl.divider_count_test ? c.ws_vco_cnt : s.wvco};
            A_FAST_DAC: r = {2'h0, s.fdac};
            A_BOOST_DAC: r = {2'h0, s.bdac};
            A_HYST_DAC: r = {1'b0, s.hdac};
            A_SRV_FAST: r = {2'h0, s.sfdac};
            A_SRV_BOOST: r = {2'h0, s.sbdac};
            A_SRV_HYST: r = {1'b0, s.shdac};
            A_TEST_SEL: r = s.tsel;
            A_TEST_READ_ONE: r = s.ctl.phase_det_io_test ? c.pd_status : 8'h00;
            default: begin
                if (hit && s.ctl.pattern_recognizer_test) begin
                    r = {c.pattern_recognizer_test_data, 2'b00, c.pattern_recognizer_test_sel};
                end else if (hit && idx == PRECOMP_LAST) begin
                    r = {s.nib[{idx, 1'b0}], s.nib[{idx, 1'b1}]};
                end else if (hit) begin
                    r = {s.nib[{idx, 1'b1}], s.nib[{idx, 1'b0}]};
                end
            end
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Bus qualification
    // ------------------------------------------------------------

    // Pads decouple while a disk access is busy unless overridden
    assign hr = q.s2.hard_reset_in;
    assign pd_any = q.chan[CC_SOFT_PD] | q.chan[CC_FULL_PD];
    assign busy = q.s2.read_gate | q.s2.encoder_enable;
    assign bus_ok = !busy | q.chan[CC_BUSY_OVERRIDE];
    assign wr_now = !q.s2.wr_n & !q.s2.cs_n;
    assign commit = q.wr_act & !wr_now & bus_ok;
    assign {wpc_hit, wpc_idx} = precomp_decode(q.addr);
    assign test_eff = q.tsel & {8{q.chan[CC_TEST_UNLOCK]}};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;

        // Address latch and write strobe tracking
        if (q.s2.ale) begin
            d.addr = q.s2.ad;
        end
        d.wr_act = wr_now;
        if (wr_now) begin
            d.wdat = q.s2.ad;
        end

        // Register writes at the end of the write strobe
        if (!q.ctl.pattern_recognizer_test) begin
            d.pconst_v = 1'b0;
        end
        if (commit) begin
            case (q.addr)
                A_CHAN_CTL: d.chan = q.wdat;
                A_DECODE_POL: d.dpc = q.wdat;
                A_PORT_VER: d.port = q.wdat[4:0];
                A_SYNTH_REF: d.sref = q.wdat;
                A_SYNTH_VCO: d.svco = q.wdat;
                A_WIN_REF: d.wref = q.wdat[3:0];
                A_WIN_VCO: d.wvco = q.wdat[4:0];
                A_FAST_DAC: d.fdac = q.wdat[5:0];
                A_BOOST_DAC: d.bdac = q.wdat[5:0];
                A_HYST_DAC: d.hdac = q.wdat[6:0];
                A_SRV_FAST: d.sfdac = q.wdat[5:0];
                A_SRV_BOOST: d.sbdac = q.wdat[5:0];
                A_SRV_HYST: d.shdac = q.wdat[6:0];
                A_TEST_SEL: d.tsel = q.wdat;
                default: begin
                    if (wpc_hit && q.ctl.pattern_recognizer_test) begin
                        d.pconst = q.wdat[4:0];
                        d.pconst_v = 1'b1;
                    end else if (wpc_hit && wpc_idx == PRECOMP_LAST) begin
                        d.nib[{wpc_idx, 1'b0}] = q.wdat[7:4];
                        d.nib[{wpc_idx, 1'b1}] = q.wdat[3:0];
                    end else if (wpc_hit) begin
                        d.nib[{wpc_idx, 1'b1}] = q.wdat[7:4];
                        d.nib[{wpc_idx, 1'b0}] = q.wdat[3:0];
                    end
                end
            endcase
        end

        // Decoder error wins over a clearing write
        if (core_i.dec_err_evt) begin
            d.dpc[DP_DEC_ERR] = 1'b1;
        end

        // Soft reset holds registers; ports and converters are kept
        if (pd_any) begin
            d.chan = d.chan & PD_KEEP_MASK;
            d.dpc = DECODE_POL_RST;
            d.tsel = TEST_RST;
            d.sref = DIV8_ONES;
            d.svco = DIV8_ONES;
            d.wref = DIV4_ONES;
            d.wvco = DIV5_ONES;
            d.nib = '0;
            d.pconst = 5'h00;
            d.pconst_v = 1'b0;
        end

        // Full powerdown also clears converters and soft powerdown bit
        if (q.chan[CC_FULL_PD]) begin
            d.chan[CC_SOFT_PD] = 1'b0;
            d.fdac = 6'h00;
            d.bdac = 6'h00;
            d.hdac = 7'h00;
            d.sfdac = 6'h00;
            d.sbdac = 6'h00;
            d.shdac = 7'h00;
        end

        // Pads drive read data only while the bus is coupled and powered
        d.ad_oe = !q.s2.rd_n & !q.s2.cs_n & bus_ok & !pd_any;
        d.ad = d.ad_oe ? read_word(q, core_i, wpc_hit, wpc_idx) : 8'h00;

        // Data path conditioning
        d.rp = q.s2.read_pulse_in ^ !q.dpc[DP_RAW_POL];
        d.wpc = (core_i.wpc_data_int & !(q.ctl.write_dc_erase_test & core_i.disk_writing))
                ^ !q.dpc[DP_WR_POL];
        d.dly = q.dpc[DP_WMON] & core_i.delayed_read_out_int;
        d.wck = q.dpc[DP_WMON] & core_i.window_clock_out_int;

        // Control outputs to the channel
        d.ctl.illegal_code_fill_select = q.dpc[DP_FILL];
        d.ctl.window_monitor_enable = q.dpc[DP_WMON];
        d.ctl.velocity_lock_sel = {q.dpc[DP_VLOCK_HI], q.dpc[DP_VLOCK_LO]};
        d.ctl.reference_prescale_enable = q.dpc[DP_PRESCALE];
        d.ctl.synth_ref_div = q.sref;
        d.ctl.synth_vco_div = q.svco;
        d.ctl.window_ref_div = q.wref;
        d.ctl.window_vco_div = q.wvco;
        d.ctl.precomp_nibbles = q.nib;
        d.ctl.precomp_const_valid = q.pconst_v & q.ctl.pattern_recognizer_test;
        d.ctl.precomp_const = q.pconst;
        d.ctl.fast_dac = 6'(dac_pick({1'b0, q.fdac}, {1'b0, q.sfdac}, q.s2.servo_gate));
        d.ctl.boost_dac = 6'(dac_pick({1'b0, q.bdac}, {1'b0, q.sbdac}, q.s2.servo_gate));
        d.ctl.hyst_dac = dac_pick(q.hdac, q.shdac, q.s2.servo_gate);
        d.ctl.soft_powerdown = q.chan[CC_SOFT_PD];
        d.ctl.full_soft_powerdown = q.chan[CC_FULL_PD];
        d.ctl.phase_det_io_test = test_eff[T_PHASE_DET_IO_TEST];
        d.ctl.synth_block_ref = test_eff[T_UP] & !test_eff[T_DN];
        d.ctl.synth_block_vco = test_eff[T_DN] & !test_eff[T_UP];
        d.ctl.synth_open_loop_test = test_eff[T_OPEN];
        d.ctl.divider_count_test = test_eff[T_CNT];
        d.ctl.internal_loop_test = test_eff[T_ILB];
        d.ctl.write_dc_erase_test = test_eff[T_DC];
        d.ctl.pattern_recognizer_test = test_eff[T_PATTERN_RECOGNIZER_TEST];

        // Hard reset pin restores initial values and floats ports
        if (hr) begin
            d = ST_RST;
        end

        // Two-stage synchronisers for all pins
        d.s1 = pins_i;
        d.s2 = q.s1;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= ST_RST;
        end else begin
            q <= d;
        end
    end

    // Outputs straight from state, except port_o, which is tied to zero
    assign ad_o = q.ad;
    assign ad_oe = q.ad_oe;
    assign port_o = 5'h00;
    assign port_oe = q.port;
    assign read_pulse_norm = q.rp;
    assign precomp_write_out = q.wpc;
    assign delayed_read_out = q.dly;
    assign window_clock_out = q.wck;
    assign ctl_o = q.ctl;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking a_cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);

    a_dec_flag_set: assert property (core_i.dec_err_evt && !pd_any && !hr |=> q.dpc[DP_DEC_ERR])
        else $error("decoder error event lost");

    a_port_hard_clear: assert property (hr |=> port_oe == 5'h00)
        else $error("ports not floated by hard reset");

    a_version_read: assert property (ad_oe && $past(q.addr) == A_PORT_VER |-> ad_o[7:5] == VERSION_ID)
        else $error("version field wrong");

    a_full_pd_dacs: assert property (q.chan[CC_FULL_PD] && !hr |=> q.fdac == 6'h00 && q.hdac == 7'h00)
        else $error("converters kept in full powerdown");

    a_servo_select: assert property (q.s2.servo_gate && !hr |=> ctl_o.fast_dac == $past(q.sfdac))
        else $error("servo bank not selected");

    a_test_lock: assert property (!q.chan[CC_TEST_UNLOCK] && !hr |=> ctl_o.write_dc_erase_test == 1'b0 ##0
                                  !ctl_o.synth_block_ref && !ctl_o.pattern_recognizer_test)
        else $error("test active while locked");

    a_pump_exclusive: assert property (q.chan[CC_TEST_UNLOCK] && q.tsel[T_UP] && q.tsel[T_DN] && !hr
                                       |=> !ctl_o.synth_block_ref && !ctl_o.synth_block_vco)
        else $error("both pump tests active");

    a_pd_read: assert property (ad_oe && $past(q.addr) == A_TEST_READ_ONE && $past(ctl_o.phase_det_io_test)
                                |-> ad_o == $past(core_i.pd_status))
        else $error("phase detector read wrong");

    a_dc_erase: assert property (ctl_o.write_dc_erase_test && core_i.disk_writing && !hr
                                 |=> precomp_write_out == !$past(q.dpc[DP_WR_POL]))
        else $error("write output not held inactive");

    a_busy_decouple: assert property (busy && !q.chan[CC_BUSY_OVERRIDE] |=> !ad_oe)
        else $error("pads driven while busy");

endmodule

// ==== sim/dcr_host_model.sv ====
/*
 Host processor model on the multiplexed address/data bus.
 Assumes the bench clock core_clk and a top module tb that counts mismatches.
*/
`timescale 1ns/100ps
module dcr_host_model
    import dcr_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] ad_o,
    input wire logic ad_oe,
    output logic ale,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [7:0] ad
);
    // Idle bus at time zero
    initial begin
        ale = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
        ad = 8'h00;
    end
    // Address phase, held across the input synchroniser
    task automatic addr_phase(input logic [7:0] a);
        @(negedge core_clk);
        ale = 1'b1;
        ad = a;
        repeat (4) @(negedge core_clk);
        ale = 1'b0;
    endtask
    // Write cycle; released data lines show the inverse value
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_phase(a);
        ad = d;
        cs_n = 1'b0;
        wr_n = 1'b0;
        repeat (4) @(negedge core_clk);
        cs_n = 1'b1;
        wr_n = 1'b1;
        @(negedge core_clk);
        ad = ~d;
        repeat (6) @(negedge core_clk);
    endtask
    // Read cycle, waits for the pads under a bound
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        addr_phase(a);
        ad = ~a;
        cs_n = 1'b0;
        rd_n = 1'b0;
        n = 0;
        while (ad_oe !== 1'b1 && n < 10) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 10) begin
            tb.miscompares++;
            tb.final_report();
        end else begin
            d = ad_o;
            cs_n = 1'b1;
            rd_n = 1'b1;
            repeat (5) @(negedge core_clk);
        end
    endtask
endmodule

// ==== sim/tb.sv ====
/*
 Self-checking bench for the channel register bank.
 Assumes the host model drives the bus and the bench drives channel inputs.
*/
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
    import dcr_pkg::*;
    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic ale, cs_n, rd_n, wr_n, ad_oe, rpn, pwo, dro, wco;
    logic [7:0] ad, ad_o, r;
    logic [4:0] port_o, port_oe;
    logic hrst = 1'b0, rp = 1'b0, sg = 1'b0, rg = 1'b0;
    dcr_core_in_t core = '0;
    dcr_pins_t pins;
    dcr_ctl_t ctl;
    int miscompares = 0;
    int n_compared = 0;

    // ----------------------------------------
    // Clock, pins and instances
    // ----------------------------------------
    always #12.5 core_clk = ~core_clk;
    always_comb pins = '{ale: ale, cs_n: cs_n, rd_n: rd_n, wr_n: wr_n, ad: ad, hard_reset_in: hrst,
        read_pulse_in: rp, servo_gate: sg, read_gate: rg, encoder_enable: 1'b0};
    dcr_host_model host_i (.core_clk(core_clk), .ad_o(ad_o), .ad_oe(ad_oe), .ale(ale), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .ad(ad));
    dcr_regs dcr_regs_i (.core_clk(core_clk), .arst_n(arst_n), .pins_i(pins), .core_i(core), .ad_o(ad_o),
        .ad_oe(ad_oe), .port_o(port_o), .port_oe(port_oe), .read_pulse_norm(rpn), .precomp_write_out(pwo),
        .delayed_read_out(dro), .window_clock_out(wco), .ctl_o(ctl));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
        host_i.rd(a, r);
        `CHK(r, e)
    endtask
    task automatic final_report;
        if (miscompares == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        final_report();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(negedge core_clk);
        arst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        `CHK(ctl.full_soft_powerdown, 1'b1)
        host_i.wr(A_CHAN_CTL, 8'h00);
        chk_rd(A_SYNTH_REF, 8'hFF);
        chk_rd(A_WIN_REF, 8'h0F);
        host_i.wr(A_SYNTH_VCO, 8'h81);
        chk_rd(A_SYNTH_VCO, 8'h81);
        host_i.wr(A_WIN_REF, 8'hF8);
        chk_rd(A_WIN_REF, 8'h08);
        host_i.wr(A_WIN_VCO, 8'hF0);
        `CHK(ctl.window_vco_div, 5'h10)
        // Configuration bits
        core.delayed_read_out_int = 1'b1;
        core.window_clock_out_int = 1'b1;
        core.wpc_data_int = 1'b1;
        rp = 1'b1;
        host_i.wr(A_DECODE_POL, 8'hFE);
        `CHK(ctl.illegal_code_fill_select, 1'b1)
        `CHK(ctl.reference_prescale_enable, 1'b1)
        `CHK(dro, 1'b1)
        `CHK(wco, 1'b1)
        `CHK(rpn, 1'b1)
        `CHK(pwo, 1'b1)
        host_i.wr(A_DECODE_POL, 8'h00);
        `CHK(dro, 1'b0)
        `CHK(wco, 1'b0)
        `CHK(rpn, 1'b0)
        `CHK(pwo, 1'b0)
        for (int i = 0; i < 4; i++) begin
            host_i.wr(A_DECODE_POL, {1'b0, 2'(i), 5'h00});
            `CHK(ctl.velocity_lock_sel, 2'(i))
        end
        // Decoder error flag
        core.dec_err_evt = 1'b1;
        @(negedge core_clk);
        core.dec_err_evt = 1'b0;
        chk_rd(A_DECODE_POL, 8'h61);
        host_i.wr(A_DECODE_POL, 8'h00);
        chk_rd(A_DECODE_POL, 8'h00);
        // Ports, version and converters
        host_i.wr(A_PORT_VER, 8'hFF);
        chk_rd(A_PORT_VER, 8'h3F);
        `CHK(port_oe, 5'h1F)
        `CHK(port_o, 5'h00)
        host_i.wr(A_FAST_DAC, 8'hFF);
        host_i.wr(A_SRV_FAST, 8'h21);
        host_i.wr(A_HYST_DAC, 8'hFF);
        `CHK(ctl.fast_dac, 6'h3F)
        `CHK(ctl.hyst_dac, 7'h7F)
        sg = 1'b1;
        repeat (4) @(negedge core_clk);
        `CHK(ctl.fast_dac, 6'h21)
        sg = 1'b0;
        host_i.wr(A_CHAN_CTL, 8'h08);
        `CHK(ctl.fast_dac, 6'h3F)
        `CHK(port_oe, 5'h1F)
        host_i.wr(A_CHAN_CTL, 8'h10);
        `CHK(ctl.fast_dac, 6'h00)
        `CHK(port_oe, 5'h1F)
        // Busy lockout and override
        host_i.wr(A_CHAN_CTL, 8'h00);
        rg = 1'b1;
        host_i.wr(A_SYNTH_REF, 8'h55);
        rg = 1'b0;
        chk_rd(A_SYNTH_REF, 8'hFF);
        host_i.wr(A_CHAN_CTL, 8'h04);
        rg = 1'b1;
        host_i.wr(A_SYNTH_REF, 8'h55);
        chk_rd(A_SYNTH_REF, 8'h55);
        rg = 1'b0;
        // Test modes
        host_i.wr(A_CHAN_CTL, 8'h00);
        host_i.wr(A_TEST_SEL, 8'h02);
        `CHK(ctl.synth_block_ref, 1'b0)
        host_i.wr(A_CHAN_CTL, 8'h80);
        `CHK(ctl.synth_block_ref, 1'b1)
        host_i.wr(A_TEST_SEL, 8'h04);
        `CHK(ctl.synth_block_vco, 1'b1)
        host_i.wr(A_TEST_SEL, 8'h06);
        `CHK({ctl.synth_block_ref, ctl.synth_block_vco}, 2'b00)
        host_i.wr(A_TEST_SEL, 8'h28);
        `CHK({ctl.synth_open_loop_test, ctl.internal_loop_test}, 2'b11)
        host_i.wr(A_TEST_SEL, 8'h50);
        core.fs_ref_cnt = 8'hA5;
        core.ws_vco_cnt = 5'h13;
        core.disk_writing = 1'b1;
        chk_rd(A_SYNTH_REF, 8'hA5);
        chk_rd(A_WIN_VCO, 8'h13);
        `CHK(pwo, 1'b1)
        host_i.wr(A_TEST_SEL, 8'h01);
        core.pd_status = 8'h5A;
        chk_rd(A_TEST_READ_ONE, 8'h5A);
        host_i.wr(A_TEST_SEL, 8'h80);
        core.pattern_recognizer_test_sel = 5'h15;
        core.pattern_recognizer_test_data = 1'b1;
        chk_rd(A_PRECOMP_BASE, 8'h95);
        host_i.wr(A_PRECOMP_BASE + 8'h03, 8'hE6);
        `CHK({ctl.precomp_const_valid, ctl.precomp_const}, 6'h26)
        `CHK(ctl.precomp_nibbles[7], 4'h0)
        // Precompensation nibble order
        host_i.wr(A_TEST_SEL, 8'h00);
        `CHK(ctl.precomp_const_valid, 1'b0)
        host_i.wr(A_PRECOMP_BASE, 8'h21);
        `CHK({ctl.precomp_nibbles[1], ctl.precomp_nibbles[0]}, 8'h21)
        host_i.wr(A_PRECOMP_BASE + 8'h0A, 8'h43);
        `CHK({ctl.precomp_nibbles[21], ctl.precomp_nibbles[20]}, 8'h34)
        // Hard reset pin clears ports
        hrst = 1'b1;
        repeat (4) @(negedge core_clk);
        hrst = 1'b0;
        repeat (3) @(negedge core_clk);
        `CHK(port_oe, 5'h00)
        `CHK(ctl.full_soft_powerdown, 1'b1)
        final_report();
    end
endmodule
